// [hdl/asac_setup_config.sv]
// Address switch decode, guider-block input and setup parameter service over AXI4-Lite
`timescale 1ns/1ps
`include "asac_defines.svh"

module asac_setup_config
    import asac_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        clkEn,
    input  wire logic [7:0]  dipSwitch,
    input  wire logic        guiderBlock,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output      logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output      logic        s_axi_wready,
    output      logic [1:0]  s_axi_bresp,
    output      logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output      logic        s_axi_arready,
    output      logic [31:0] s_axi_rdata,
    output      logic [1:0]  s_axi_rresp,
    output      logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output      logic [3:0]  deviceNumber,
    output      logic [2:0]  groupNumber,
    output      logic        addressValid,
    output      logic        setupLocked,
    output      logic        setupActive,
    output      logic        holdPosition,
    output      logic        autoModeRequest,
    output      logic [15:0] webOffset,
    output      logic [2:0]  controlMode,
    output      logic        expandedSetup,
    output      asac_pulse_t servicePulse
);

    asac_state_t state_reg;
    asac_state_t state_next;

    // Decoded views of the debounced switches
    logic [3:0]  swDev;
    logic [2:0]  swGrp;
    logic        swLock;
    logic        setupOk;
    logic        devValid;
    logic        minimalMode;
    logic        doWrite;
    logic        wrAccept;
    logic        wrKnown;
    logic [31:0] wd;
    logic [31:0] statusWord;
    logic [31:0] rdWord;
    logic        rdKnown;

    // Leftmost switch of each field is its most significant bit
    assign swDev  = {state_reg.dipStable[0], state_reg.dipStable[1],
                     state_reg.dipStable[2], state_reg.dipStable[3]};
    assign swGrp  = {state_reg.dipStable[4], state_reg.dipStable[5],
                     state_reg.dipStable[6]};
    assign swLock = state_reg.dipStable[7];

    // Lock switch overrides any software request
    assign setupOk     = state_reg.setupReq & ~swLock;
    assign devValid    = (state_reg.devNum >= `ASAC_VALID_DEV_LO) &&
                         (state_reg.devNum <= `ASAC_VALID_DEV_HI);
    assign minimalMode = (state_reg.ctrlMode == `ASAC_MODE_MINIMAL);
    assign wd          = state_reg.wData;

    // Status word, built from live state
    always_comb begin
        statusWord                          = 32'h0000_0000;
        statusWord[3:0]                     = swDev;
        statusWord[6:4]                     = swGrp;
        statusWord[`ASAC_STAT_LOCK_BIT]     = swLock;
        statusWord[`ASAC_STAT_VALID_BIT]    = devValid;
        statusWord[`ASAC_STAT_BLOCK_BIT]    = state_reg.blkStable;
        statusWord[`ASAC_STAT_HOLD_BIT]     = holdPosition;
        statusWord[`ASAC_STAT_AUTO_BIT]     = autoModeRequest;
        statusWord[`ASAC_STAT_SETUP_BIT]    = setupOk;
        statusWord[`ASAC_STAT_EXP_BIT]      = state_reg.expanded;
    end

    // Read decode; parameters stay readable outside setup mode
    always_comb begin
        rdKnown = 1'b1;
        unique case (s_axi_araddr)
            `ASAC_OFS_DEVICE:    rdWord = {28'h000_0000, state_reg.devNum};
            `ASAC_OFS_GROUP:     rdWord = {29'h0000_0000, state_reg.grpNum};
            `ASAC_OFS_RESTORE:   rdWord = {30'h0000_0000, state_reg.restoreVal};
            `ASAC_OFS_SERVICE:   rdWord = {24'h00_0000, state_reg.serviceVal};
            `ASAC_OFS_VERSION:   rdWord = `ASAC_VERSION_RST;
            `ASAC_OFS_WEBOFFSET: rdWord = {{16{state_reg.webOffset[15]}}, state_reg.webOffset};
            `ASAC_OFS_CTRLMODE:  rdWord = {29'h0000_0000, state_reg.ctrlMode};
            `ASAC_OFS_SETUP:     rdWord = {31'h0000_0000, state_reg.setupReq};
            `ASAC_OFS_STATUS:    rdWord = statusWord;
            default: begin
                rdWord  = 32'h0000_0000;
                rdKnown = 1'b0;
            end
        endcase
    end

    // Write validation: address known, full word, setup open, value in range
    assign doWrite = state_reg.awHeld & state_reg.wHeld & ~state_reg.bValid;
    always_comb begin
        wrKnown  = 1'b1;
        wrAccept = 1'b0;
        unique case (state_reg.awAddr)
            `ASAC_OFS_DEVICE:    wrAccept = (wd[31:4] == 28'h000_0000) &&
                                            (wd[3:0] >= `ASAC_DEV_MIN) && (wd[3:0] <= `ASAC_DEV_MAX);
            `ASAC_OFS_GROUP:     wrAccept = (wd[31:3] == 29'h0000_0000);
            `ASAC_OFS_RESTORE:   wrAccept = (wd[31:2] == 30'h0000_0000) &&
                                            (wd[1:0] <= `ASAC_RESTORE_MAX);
            `ASAC_OFS_SERVICE:   wrAccept = (wd[31:8] == 24'h00_0000);
            `ASAC_OFS_WEBOFFSET: wrAccept = ($signed(wd) >= 32'(`ASAC_OFFSET_MIN)) &&
                                            ($signed(wd) <= 32'(`ASAC_OFFSET_MAX));
            `ASAC_OFS_CTRLMODE:  wrAccept = (wd[31:3] == 29'h0000_0000) &&
                                            (wd[2:0] <= `ASAC_MODE_MAX);
            `ASAC_OFS_SETUP:     wrAccept = 1'b1;
            `ASAC_OFS_VERSION,
            `ASAC_OFS_STATUS:    wrAccept = 1'b0;
            default:             wrKnown  = 1'b0;
        endcase
        // Parameters other than the setup request need an open setup mode
        if (state_reg.awAddr != `ASAC_OFS_SETUP && !setupOk) begin
            wrAccept = 1'b0;
        end
        if (state_reg.wStrb != 4'hF) begin
            wrAccept = 1'b0;
        end
    end

    // Next-state logic
    always_comb begin
        state_next       = state_reg;
        state_next.pulse = '0;

        // Three-stage sync; a change counts once stages two and three agree
        state_next.dipS1 = dipSwitch;
        state_next.dipS2 = state_reg.dipS1;
        state_next.dipS3 = state_reg.dipS2;
        state_next.blkS  = {state_reg.blkS[1:0], guiderBlock};
        if (state_reg.dipS2 == state_reg.dipS3) begin
            state_next.dipStable = state_reg.dipS3;
        end
        if (state_reg.blkS[1] == state_reg.blkS[2]) begin
            state_next.blkStable = state_reg.blkS[2];
        end

        // Load the address once the chain has filled and the stable copy has caught up;
        // a bank that keeps bouncing delays the load rather than latching a half-settled value
        if (!state_reg.loaded) begin
            if (state_reg.settleCnt != `ASAC_SETTLE_CYCLES) begin
                state_next.settleCnt = state_reg.settleCnt + 2'h1;
            end else if (state_reg.dipS3 == state_reg.dipStable) begin
                state_next.loaded = 1'b1;
                state_next.devNum = swDev;
                state_next.grpNum = swGrp;
            end
        end

        // Address and data channels are taken independently
        if (s_axi_awvalid && !state_reg.awHeld) begin
            state_next.awHeld = 1'b1;
            state_next.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_reg.wHeld) begin
            state_next.wHeld = 1'b1;
            state_next.wData = s_axi_wdata;
            state_next.wStrb = s_axi_wstrb;
        end

        // Execute a write once both halves are in
        if (doWrite) begin
            state_next.awHeld = 1'b0;
            state_next.wHeld  = 1'b0;
            state_next.bValid = 1'b1;
            state_next.bResp  = !wrKnown ? `ASAC_RESP_DECERR :
                                wrAccept ? `ASAC_RESP_OKAY : `ASAC_RESP_SLVERR;
            if (wrKnown && wrAccept) begin
                unique case (state_reg.awAddr)
                    `ASAC_OFS_DEVICE:    state_next.devNum = wd[3:0];
                    `ASAC_OFS_GROUP:     state_next.grpNum = wd[2:0];
                    `ASAC_OFS_WEBOFFSET: state_next.webOffset = wd[15:0];
                    `ASAC_OFS_CTRLMODE:  state_next.ctrlMode = wd[2:0];
                    `ASAC_OFS_SETUP:     state_next.setupReq = wd[0];
                    `ASAC_OFS_RESTORE: begin
                        state_next.restoreVal = wd[1:0];
                        // Defaults also return the tunables to their reset values
                        if (wd[1:0] == `ASAC_RESTORE_DFLT) begin
                            state_next.pulse.restoreDefault = 1'b1;
                            state_next.webOffset = 16'h0000;
                            state_next.ctrlMode  = 3'h0;
                        end
                        state_next.pulse.restoreCustomer = (wd[1:0] == `ASAC_RESTORE_CUST);
                    end
                    `ASAC_OFS_SERVICE: begin
                        state_next.serviceVal = wd[7:0];
                        unique case (wd[7:0])
                            `ASAC_SVC_RESET:    state_next.pulse.resetGuider = 1'b1;
                            `ASAC_SVC_SAVE:     state_next.pulse.saveParams  = 1'b1;
                            `ASAC_SVC_BACKUP:   state_next.pulse.saveBackup  = 1'b1;
                            `ASAC_SVC_ERASE:    state_next.pulse.eraseMemory = 1'b1;
                            `ASAC_SVC_EXPAND: begin
                                state_next.pulse.expandSetup = 1'b1;
                                state_next.expanded          = 1'b1;
                            end
                            // Calibrations only for the matching device role
                            `ASAC_SVC_CALPIVOT:
                                state_next.pulse.calPivot = (state_reg.devNum == `ASAC_DEV_PIVOT);
                            `ASAC_SVC_CALGEAR:
                                state_next.pulse.calPivotGear = (state_reg.devNum == `ASAC_DEV_PIVOT);
                            `ASAC_SVC_CALBEAM:
                                state_next.pulse.calBeam = (state_reg.devNum >= `ASAC_DEV_BEAM_LO) &&
                                                           (state_reg.devNum <= `ASAC_VALID_DEV_HI);
                            default: ;
                        endcase
                    end
                    default: ;
                endcase
            end
        end
        if (state_reg.bValid && s_axi_bready) begin
            state_next.bValid = 1'b0;
        end

        // Read: one outstanding, answer the cycle after the address
        if (s_axi_arvalid && !state_reg.rValid) begin
            state_next.rValid = 1'b1;
            state_next.rData  = rdWord;
            state_next.rResp  = rdKnown ? `ASAC_RESP_OKAY : `ASAC_RESP_DECERR;
        end else if (state_reg.rValid && s_axi_rready) begin
            state_next.rValid = 1'b0;
        end

        // Leaving setup mode drops the expanded view as well
        if (!setupOk) begin
            state_next.expanded = 1'b0;
        end
    end

    // State register; clock enable freezes everything
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= '0;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end

    // Bus handshakes
    assign s_axi_awready = ~state_reg.awHeld;
    assign s_axi_wready  = ~state_reg.wHeld;
    assign s_axi_bvalid  = state_reg.bValid;
    assign s_axi_bresp   = state_reg.bResp;
    assign s_axi_arready = ~state_reg.rValid;
    assign s_axi_rvalid  = state_reg.rValid;
    assign s_axi_rdata   = state_reg.rData;
    assign s_axi_rresp   = state_reg.rResp;

    // Block outputs
    assign deviceNumber    = state_reg.devNum;
    assign groupNumber     = state_reg.grpNum;
    assign addressValid    = devValid & state_reg.loaded;
    assign setupLocked     = swLock;
    assign setupActive     = setupOk;
    assign holdPosition    = state_reg.blkStable & ~minimalMode;
    assign autoModeRequest = state_reg.blkStable & minimalMode;
    assign webOffset       = state_reg.webOffset;
    assign controlMode     = state_reg.ctrlMode;
    assign expandedSetup   = state_reg.expanded;
    assign servicePulse    = state_reg.pulse;

endmodule // asac_setup_config

// [common/asac_defines.svh]
// Constants for the actuator setup and address configuration block
//
// Behaviour
// - The device number is the binary value on address switches one to four.
// - The group number is the binary value on switches five to seven, and with the device number forms the address.
// - Switch eight is not part of the address and, when set, blocks entry into setup mode.
// - Each switch field is read with its leftmost switch as the most significant bit.
// - Only device numbers five to eleven are valid, each selecting one controller role.
// - While the guider-block contact is closed the actuator holds its position, resuming when it opens.
// - In minimal-operation control mode the guider-block input is the automatic-mode request instead.
// - In setup mode parameters may be read, and only the changeable ones may be written.
// - Parameter zero sets the device number, limited to 01 through 0F hex.
// - Parameter one sets the group number, limited to 00 through 07 hex.
// - The settings-restore parameter takes 0 to 2; 1 loads customer settings, 2 loads internal defaults.
// - Service codes 1, 2, 42, 44 and 99 reset the guider, save, expand setup, save with backup and erase memory.
// - Codes 10 and 12 calibrate the pivot frame for device five; code 11 calibrates the beam for devices six to eleven.
// - The web-offset parameter holds an automatic-mode setpoint between -3250.0 and 3250.0 mm.
`ifndef ASAC_DEFINES_SVH
`define ASAC_DEFINES_SVH

// Register byte offsets
`define ASAC_OFS_DEVICE     8'h00
`define ASAC_OFS_GROUP      8'h04
`define ASAC_OFS_RESTORE    8'h08
`define ASAC_OFS_SERVICE    8'h0C
`define ASAC_OFS_VERSION    8'h10
`define ASAC_OFS_WEBOFFSET  8'h14
`define ASAC_OFS_CTRLMODE   8'h18
`define ASAC_OFS_SETUP      8'h1C
`define ASAC_OFS_STATUS     8'h20

// Parameter limits
`define ASAC_DEV_MIN        4'h1
`define ASAC_DEV_MAX        4'hF
`define ASAC_GRP_MAX        3'h7
`define ASAC_RESTORE_MAX    2'h2
`define ASAC_OFFSET_MIN     (-16'sd32500)
`define ASAC_OFFSET_MAX     (16'sd32500)
`define ASAC_MODE_MAX       3'h5
`define ASAC_MODE_MINIMAL   3'h2
`define ASAC_VALID_DEV_LO   4'h5
`define ASAC_VALID_DEV_HI   4'hB
`define ASAC_DEV_PIVOT      4'h5
`define ASAC_DEV_BEAM_LO    4'h6

// Restore values
`define ASAC_RESTORE_CUST   2'h1
`define ASAC_RESTORE_DFLT   2'h2

// Service codes
`define ASAC_SVC_RESET      8'h01
`define ASAC_SVC_SAVE       8'h02
`define ASAC_SVC_CALPIVOT   8'h0A
`define ASAC_SVC_CALBEAM    8'h0B
`define ASAC_SVC_CALGEAR    8'h0C
`define ASAC_SVC_EXPAND     8'h2A
`define ASAC_SVC_BACKUP     8'h2C
`define ASAC_SVC_ERASE      8'h63

// Reset values and field positions
`define ASAC_VERSION_RST    32'h0000_000F
`define ASAC_STAT_LOCK_BIT  8
`define ASAC_STAT_VALID_BIT 9
`define ASAC_STAT_BLOCK_BIT 10
`define ASAC_STAT_HOLD_BIT  11
`define ASAC_STAT_AUTO_BIT  12
`define ASAC_STAT_SETUP_BIT 13
`define ASAC_STAT_EXP_BIT   14
`define ASAC_SETTLE_CYCLES  2'h3

// AXI responses
`define ASAC_RESP_OKAY      2'h0
`define ASAC_RESP_SLVERR    2'h2
`define ASAC_RESP_DECERR    2'h3

`endif

// [common/asac_pkg.sv]
// Types of the actuator setup and address configuration block
package asac_pkg;

    // One-cycle service and restore strobes
    typedef struct packed {
        logic resetGuider;
        logic saveParams;
        logic saveBackup;
        logic expandSetup;
        logic eraseMemory;
        logic calPivot;
        logic calPivotGear;
        logic calBeam;
        logic restoreCustomer;
        logic restoreDefault;
    } asac_pulse_t;

    // Whole state of the block
    typedef struct packed {
        logic [7:0]  dipS1;
        logic [7:0]  dipS2;
        logic [7:0]  dipS3;
        logic [2:0]  blkS;
        logic [7:0]  dipStable;
        logic        blkStable;
        logic [1:0]  settleCnt;
        logic        loaded;
        logic [3:0]  devNum;
        logic [2:0]  grpNum;
        logic [1:0]  restoreVal;
        logic [7:0]  serviceVal;
        logic [15:0] webOffset;
        logic [2:0]  ctrlMode;
        logic        setupReq;
        logic        expanded;
        asac_pulse_t pulse;
        logic        awHeld;
        logic [7:0]  awAddr;
        logic        wHeld;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
    } asac_state_t;

endpackage

// [tb/asac_station.sv]
// Command station model: AXI4-Lite master for parameter access
`timescale 1ns/1ps
module asac_station (
    input  wire logic        clk,
    output      logic [7:0]  s_axi_awaddr,
    output      logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output      logic [31:0] s_axi_wdata,
    output      logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output      logic        s_axi_bready,
    output      logic [7:0]  s_axi_araddr,
    output      logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output      logic        s_axi_rready
);
    // Idle bus at time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end

    // Sampled at the falling edge, so a handshake is judged on pre-edge values
    task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa;
        logic pw;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        while (pa || pw) begin
            @(negedge clk);
            if (s_axi_awready) pa = 1'b0;
            if (s_axi_wready) pw = 1'b0;
            @(posedge clk);
            // Released lines scrambled, never left holding the old value
            if (!pa) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (!pw) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end
        do @(negedge clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask

    // Read: address held until taken, rready until rvalid seen
    task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge clk); while (!s_axi_arready);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        do @(negedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask
endmodule // asac_station

// [tb/asac_setup_config_asserts.sv]
// Checker for switch decode, guider block and service pulses
`timescale 1ns/1ps
module asac_setup_config_asserts
    import asac_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  dipSwitch,
    input  wire logic        guiderBlock,
    input  wire logic        s_axi_arready,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic        s_axi_rvalid,
    input  wire logic [3:0]  deviceNumber,
    input  wire logic        addressValid,
    input  wire logic        setupLocked,
    input  wire logic        setupActive,
    input  wire logic        holdPosition,
    input  wire logic        autoModeRequest,
    input  wire logic [2:0]  controlMode,
    input  wire asac_pulse_t servicePulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Eight cycles covers the three-stage sync plus agreement
    a_lock_blocks: assert property (dipSwitch[7] [*8] |-> setupLocked && !setupActive)
        else $error("setup not blocked by switch eight");
    a_valid_dev: assert property (addressValid |-> deviceNumber inside {[4'h5:4'hB]})
        else $error("address valid outside five to eleven");
    a_hold_closed: assert property ((guiderBlock && controlMode != 3'h2) [*8] |-> holdPosition)
        else $error("closed contact did not hold position");
    a_hold_release: assert property (!guiderBlock [*8] |-> !holdPosition && !autoModeRequest)
        else $error("open contact still holding");
    a_auto_minimal: assert property ((guiderBlock && controlMode == 3'h2) [*8] |-> autoModeRequest)
        else $error("minimal mode contact gave no auto request");
    a_hold_not_min: assert property (holdPosition |-> controlMode != 3'h2 && !autoModeRequest)
        else $error("hold in minimal operation mode");
    a_pulse_onehot: assert property ($onehot0(servicePulse))
        else $error("more than one service pulse");
    a_pulse_on_b: assert property (|servicePulse |-> $rose(s_axi_bvalid) ##1 servicePulse == '0)
        else $error("service pulse not with write response");
    a_cal_pivot: assert property (servicePulse.calPivot || servicePulse.calPivotGear |-> deviceNumber == 4'h5)
        else $error("pivot calibration on wrong device");
    a_cal_beam: assert property (servicePulse.calBeam |-> deviceNumber inside {[4'h6:4'hB]})
        else $error("beam calibration on wrong device");
    a_b_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not cleared");
    a_r_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while answer pending");

    c_pulse: cover property (|servicePulse);
    c_hold: cover property (holdPosition);
    c_auto: cover property (autoModeRequest);
endmodule // asac_setup_config_asserts

bind asac_setup_config asac_setup_config_asserts i_asac_setup_config_asserts (.*);

// [tb/tb.sv]
// Testbench: parameter access, switch decode and guider block
`timescale 1ns/1ps
module tb
    import asac_pkg::*;
;
    logic        clk = 1'b0, nrst = 1'b0, clkEn = 1'b1, guiderBlock = 1'b0;
    logic [7:0]  dipSwitch = 8'h6A, s_axi_awaddr, s_axi_araddr;
    logic [3:0]  s_axi_wstrb = 4'hF, deviceNumber;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  groupNumber, controlMode;
    logic [15:0] webOffset;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, addressValid, setupLocked;
    logic        setupActive, holdPosition, autoModeRequest, expandedSetup;
    asac_pulse_t servicePulse, seenPulse = '0;
    int          mismatches = 0, n_compared = 0;
    // Limit table: address, value, expected response
    logic [7:0]  ra [13] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h08, 8'h14, 8'h14, 8'h14, 8'h18, 8'h24, 8'h10, 8'h18};
    logic [31:0] rv [13] = '{32'h0, 32'h10, 32'hF, 32'h8, 32'h7, 32'h3, 32'h7EF5, 32'h7EF4, 32'hFFFF_810C,
                             32'h6, 32'h0, 32'h1, 32'h2};
    logic [1:0]  rr [13] = '{2'h2, 2'h2, 2'h0, 2'h2, 2'h0, 2'h2, 2'h2, 2'h0, 2'h0, 2'h2, 2'h3, 2'h2, 2'h0};
    // Service table: address, value, expected pulse
    logic [7:0]  sa [15] = '{8'h00, 8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h08, 8'h08,
                             8'h00, 8'h0C, 8'h0C};
    logic [7:0]  sv [15] = '{8'h05, 8'h01, 8'h02, 8'h2C, 8'h2A, 8'h63, 8'h0A, 8'h0C, 8'h0B, 8'h07, 8'h01, 8'h02,
                             8'h06, 8'h0B, 8'h0A};
    logic [9:0]  sp [15] = '{10'h0, 10'h200, 10'h100, 10'h080, 10'h040, 10'h020, 10'h010, 10'h008, 10'h0, 10'h0,
                             10'h002, 10'h001, 10'h0, 10'h004, 10'h0};

    asac_setup_config i_asac_setup_config (.*);
    asac_station i_asac_station (.*);

    always #50 clk = ~clk;
    // Sticky record of service pulses, cleared when a write address is taken
    always @(posedge clk) seenPulse <= (s_axi_awvalid && s_axi_awready) ? '0 : seenPulse | servicePulse;

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        i_asac_station.write(a, d, r);
        @(negedge clk);
        chk("bresp", 32'(r), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        i_asac_station.read(a, d, r);
        chk("rdata", d, ed);
        chk("rresp", 32'(r), 32'(er));
    endtask

    task automatic end_sim;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (8000) @(posedge clk);
        mismatches++;
        end_sim();
    end

    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (10) @(negedge clk);
        chk("deviceNumber", 32'(deviceNumber), 32'h5);
        chk("groupNumber", 32'(groupNumber), 32'h3);
        chk("addressValid", 32'(addressValid), 32'h1);
        rd(8'h20, 32'h0000_0235, 2'h0);
        wr(8'h00, 32'h5, 2'h2);
        wr(8'h1C, 32'h1, 2'h0);
        chk("setupActive", 32'(setupActive), 32'h1);
        s_axi_wstrb <= 4'h3;
        wr(8'h18, 32'h1, 2'h2);
        s_axi_wstrb <= 4'hF;
        chk("controlMode", 32'(controlMode), 32'h0);
        for (int i = 0; i < 13; i++) wr(ra[i], rv[i], rr[i]);
        rd(8'h00, 32'hF, 2'h0);
        rd(8'h04, 32'h7, 2'h0);
        rd(8'h08, 32'h0, 2'h0);
        rd(8'h14, 32'hFFFF_810C, 2'h0);
        rd(8'h10, 32'hF, 2'h0);
        rd(8'h24, 32'h0, 2'h3);
        chk("webOffset", 32'(webOffset), 32'h810C);
        chk("addressValid", 32'(addressValid), 32'h0);
        for (int i = 0; i < 15; i++) begin
            wr(sa[i], 32'(sv[i]), 2'h0);
            chk("servicePulse", 32'(seenPulse), 32'(sp[i]));
        end
        chk("expandedSetup", 32'(expandedSetup), 32'h1);
        chk("webOffset", 32'(webOffset), 32'h0);
        chk("controlMode", 32'(controlMode), 32'h0);
        @(posedge clk) guiderBlock <= 1'b1;
        repeat (10) @(negedge clk);
        chk("holdPosition", 32'(holdPosition), 32'h1);
        wr(8'h18, 32'h2, 2'h0);
        chk("autoModeRequest", 32'(autoModeRequest), 32'h1);
        chk("holdPosition", 32'(holdPosition), 32'h0);
        @(posedge clk) guiderBlock <= 1'b0;
        repeat (10) @(negedge clk);
        chk("autoModeRequest", 32'(autoModeRequest), 32'h0);
        @(posedge clk) dipSwitch <= 8'hEA;
        repeat (10) @(negedge clk);
        chk("setupLocked", 32'(setupLocked), 32'h1);
        chk("setupActive", 32'(setupActive), 32'h0);
        wr(8'h00, 32'h5, 2'h2);
        chk("deviceNumber", 32'(deviceNumber), 32'h6);
        // Frozen clock enable must keep the lock despite the switch change
        @(posedge clk) clkEn <= 1'b0;
        dipSwitch <= 8'h6A;
        repeat (10) @(negedge clk);
        chk("setupLocked", 32'(setupLocked), 32'h1);
        @(posedge clk) clkEn <= 1'b1;
        repeat (10) @(negedge clk);
        chk("setupLocked", 32'(setupLocked), 32'h0);
        chk("setupActive", 32'(setupActive), 32'h1);
        end_sim();
    end
endmodule // tb
